/* File: verilog/csps_exec_regs.svh */
`ifndef CSPS_EXEC_REGS_SVH
`define CSPS_EXEC_REGS_SVH
// register word offsets on the avalon slave
`define CSPS_OFS_CMD     3'h0
`define CSPS_OFS_DST     3'h1
`define CSPS_OFS_SRC     3'h2
`define CSPS_OFS_FLAGS   3'h3
`define CSPS_OFS_PTRS    3'h4
`define CSPS_OFS_STATUS  3'h5
// opcodes handled here
`define CSPS_OPC_SUBB_IM 8'h36
`define CSPS_OPC_SETC    8'hdf
`define CSPS_OPC_ASR_R   8'hd0
`define CSPS_OPC_ASR_IR  8'hd1
`define CSPS_OPC_LDPTR   8'h31
`define CSPS_OPC_STOP    8'h7f
// pointer select codes in source bits 1:0
`define CSPS_SEL_BOTH    2'h0
`define CSPS_SEL_FIRST   2'h2
`define CSPS_SEL_SECOND  2'h1
// execution lengths in core clock cycles
`define CSPS_CYC_SHORT   3'h4
`define CSPS_CYC_LONG    3'h6
// status bit positions
`define CSPS_ST_BUSY     0
`define CSPS_ST_STOPPED  1
`define CSPS_ST_ILLEGAL  2
// reset values
`define CSPS_RST_BYTE    8'h00
`define CSPS_RST_FLAGS   6'h00
`endif

/* File: verilog/csps_pkg.sv */
package csps_pkg;
    // flag byte as held by the core, c in bit 5 down to h in bit 0
    typedef struct packed {
        logic c;
        logic z;
        logic s;
        logic v;
        logic d;
        logic h;
    } csps_flags_s;
    // execution unit states
    typedef enum logic [1:0] {
        CSPS_IDLE,
        CSPS_EXEC,
        CSPS_STOPPED
    } csps_state_e;
endpackage : csps_pkg

/* File: verilog/csps_exec.sv */
// Function
// - subtract source and carry from destination
// - set carry opcode sets c only
// - shift right keeps sign, c gets bit0
// - shift right opcodes d0 and d1
// - shift right sets z and s from result
// - shift right clears v, keeps d h
// - opcode 31 bits 1:0 choose pointers
// - single pointer takes source bits 7:3
// - both pointers: bits 7:4, bit3 0/1
// - single loads 50h and 68h land exactly
// - stop opcode 7f halts both clocks
// - stopped device retains all registers but the illegal bit, which a status write can clear
// - only reset or external interrupt wakes
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`timescale 1ns/100ps
`include "csps_exec_regs.svh"
module csps_exec (
    input  wire logic        core_clk,
    input  wire logic        reset_n,
    input  wire logic [2:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ext_irq,
    output logic             cpu_clk_en,
    output logic             sys_clk_en
);
    csps_pkg::csps_state_e state;          // execution state
    csps_pkg::csps_state_e next_state;     // its next value
    csps_pkg::csps_flags_s flags;          // flag register
    csps_pkg::csps_flags_s next_flags;     // flags after completion
    logic [7:0]            dst_op;         // destination operand
    logic [7:0]            src_op;         // source operand
    logic [7:0]            opcode;         // opcode in flight
    logic [7:0]            first_reg_pointer;
    logic [7:0]            second_reg_pointer;
    logic [7:0]            next_dst;       // destination after completion
    logic [7:0]            next_first;     // first pointer after completion
    logic [7:0]            next_second;    // second pointer after completion
    logic [2:0]            cyc_cnt;        // cycles left in the instruction
    logic                  illegal;        // sticky bad opcode flag
    logic                  acc_q;          // bus answer cycle
    // bus decode
    wire        bus_req   = avs_read | avs_write;
    wire        sel_cmd   = avs_address == `CSPS_OFS_CMD;
    wire        exec_busy = state == csps_pkg::CSPS_EXEC;
    wire        stopped   = state == csps_pkg::CSPS_STOPPED;
    // a command write waits until the running instruction is done
    wire        bus_hold  = avs_write & sel_cmd & exec_busy;
    wire        bus_start = bus_req & ~acc_q & ~bus_hold;
    wire        wr_take   = avs_write & acc_q;
    // register writes other than the status clear are frozen while stopped
    wire        wr_live   = wr_take & ~stopped;
    wire        wr_dst    = wr_live & (avs_address == `CSPS_OFS_DST);
    wire        wr_src    = wr_live & (avs_address == `CSPS_OFS_SRC);
    wire        wr_flags  = wr_live & (avs_address == `CSPS_OFS_FLAGS);
    wire        wr_ptrs   = wr_live & (avs_address == `CSPS_OFS_PTRS);
    wire        wr_status = wr_take & (avs_address == `CSPS_OFS_STATUS);
    wire        launch    = wr_live & sel_cmd & ~exec_busy;
    wire [7:0]  new_opc   = avs_writedata[7:0];
    // opcode decode
    wire        opc_long  = new_opc == `CSPS_OPC_SUBB_IM;
    wire        opc_known = opc_long
                          | (new_opc == `CSPS_OPC_SETC)
                          | (new_opc == `CSPS_OPC_ASR_R)
                          | (new_opc == `CSPS_OPC_ASR_IR)
                          | (new_opc == `CSPS_OPC_LDPTR)
                          | (new_opc == `CSPS_OPC_STOP);
    wire        go        = launch & opc_known;
    wire        bad       = launch & ~opc_known;
    wire        finish    = exec_busy & (cyc_cnt == 3'h1);
    // subtract with borrow datapath
    wire [8:0]  subb_diff = {1'b0, dst_op} - {1'b0, src_op} - {8'h00, flags.c};
    wire [4:0]  subb_half = {1'b0, dst_op[3:0]} - {1'b0, src_op[3:0]}
                          - {4'h0, flags.c};
    wire [7:0]  subb_res  = subb_diff[7:0];
    wire        subb_ovf  = (dst_op[7] != src_op[7]) & (subb_res[7] == src_op[7]);
    // arithmetic shift right datapath
    wire [7:0]  asr_res   = {dst_op[7], dst_op[7:1]};
    wire        is_asr    = (opcode == `CSPS_OPC_ASR_R) | (opcode == `CSPS_OPC_ASR_IR);
    wire [1:0]  ptr_sel   = src_op[1:0];
    // read mux
    wire [7:0]  status    = {5'h00, illegal, stopped, exec_busy};
    logic [31:0] rd_mux;

    // read data selection, unmapped words read zero
    always_comb begin
        case (avs_address)
            `CSPS_OFS_CMD:    rd_mux = {24'h000000, opcode};
            `CSPS_OFS_DST:    rd_mux = {24'h000000, dst_op};
            `CSPS_OFS_SRC:    rd_mux = {24'h000000, src_op};
            `CSPS_OFS_FLAGS:  rd_mux = {26'h0000000, flags};
            `CSPS_OFS_PTRS:   rd_mux = {16'h0000, second_reg_pointer, first_reg_pointer};
            `CSPS_OFS_STATUS: rd_mux = {24'h000000, status};
            default:          rd_mux = 32'h00000000;
        endcase
    end

    assign avs_waitrequest = bus_req & ~acc_q;

    // bus answer: one wait cycle, read data captured with it
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            acc_q        <= 1'b0;
            avs_readdata <= 32'h00000000;
        end else begin
            acc_q <= bus_start;
            if (bus_start) begin
                avs_readdata <= rd_mux;
            end
        end
    end

    // results of the instruction in flight
    always_comb begin
        next_dst    = dst_op;
        next_flags  = flags;
        next_first  = first_reg_pointer;
        next_second = second_reg_pointer;
        case (opcode)
            `CSPS_OPC_SUBB_IM: begin
                next_dst     = subb_res;
                next_flags.c = subb_diff[8];
                next_flags.z = subb_res == 8'h00;
                next_flags.s = subb_res[7];
                next_flags.v = subb_ovf;
                next_flags.d = 1'b1;
                next_flags.h = subb_half[4];
            end
            `CSPS_OPC_SETC: begin
                next_flags.c = 1'b1;
            end
            `CSPS_OPC_ASR_R, `CSPS_OPC_ASR_IR: begin
                next_dst     = asr_res;
                next_flags.c = dst_op[0];
                next_flags.z = asr_res == 8'h00;
                next_flags.s = asr_res[7];
                next_flags.v = 1'b0;
            end
            `CSPS_OPC_LDPTR: begin
                // flags untouched for every selection
                case (ptr_sel)
                    `CSPS_SEL_BOTH: begin
                        next_first  = {src_op[7:4], 1'b0, first_reg_pointer[2:0]};
                        next_second = {src_op[7:4], 1'b1, second_reg_pointer[2:0]};
                    end
                    `CSPS_SEL_FIRST: begin
                        next_first  = {src_op[7:3], first_reg_pointer[2:0]};
                    end
                    `CSPS_SEL_SECOND: begin
                        next_second = {src_op[7:3], second_reg_pointer[2:0]};
                    end
                    default: begin
                        // select 11 leaves both pointers alone
                        next_first  = first_reg_pointer;
                    end
                endcase
            end
            default: begin
                // stop changes no flag or operand
                next_dst = dst_op;
            end
        endcase
    end

    // state sequencing
    always_comb begin
        next_state = state;
        case (state)
            csps_pkg::CSPS_IDLE: begin
                if (go) begin
                    next_state = csps_pkg::CSPS_EXEC;
                end
            end
            csps_pkg::CSPS_EXEC: begin
                if (finish && opcode == `CSPS_OPC_STOP) begin
                    next_state = csps_pkg::CSPS_STOPPED;
                end else if (finish) begin
                    next_state = csps_pkg::CSPS_IDLE;
                end
            end
            csps_pkg::CSPS_STOPPED: begin
                if (ext_irq) begin
                    next_state = csps_pkg::CSPS_IDLE;
                end
            end
            default: begin
                next_state = csps_pkg::CSPS_IDLE;
            end
        endcase
    end

    // state, cycle counter and clock enables
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            state      <= csps_pkg::CSPS_IDLE;
            cyc_cnt    <= 3'h0;
            cpu_clk_en <= 1'b1;
            sys_clk_en <= 1'b1;
        end else begin
            state      <= next_state;
            cpu_clk_en <= next_state != csps_pkg::CSPS_STOPPED;
            sys_clk_en <= next_state != csps_pkg::CSPS_STOPPED;
            if (go) begin
                cyc_cnt <= opc_long ? `CSPS_CYC_LONG : `CSPS_CYC_SHORT;
            end else if (exec_busy) begin
                cyc_cnt <= cyc_cnt - 3'h1;
            end
        end
    end

    // operand and opcode registers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            dst_op <= `CSPS_RST_BYTE;
            src_op <= `CSPS_RST_BYTE;
            opcode <= `CSPS_RST_BYTE;
        end else begin
            if (finish) begin
                dst_op <= next_dst;
            end else if (wr_dst && !exec_busy) begin
                dst_op <= avs_writedata[7:0];
            end
            if (wr_src && !exec_busy) begin
                src_op <= avs_writedata[7:0];
            end
            if (go) begin
                opcode <= new_opc;
            end
        end
    end

    // flags and register pointers
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            flags              <= csps_pkg::csps_flags_s'(`CSPS_RST_FLAGS);
            first_reg_pointer  <= `CSPS_RST_BYTE;
            second_reg_pointer <= `CSPS_RST_BYTE;
        end else if (finish) begin
            flags              <= next_flags;
            first_reg_pointer  <= next_first;
            second_reg_pointer <= next_second;
        end else if (!exec_busy) begin
            if (wr_flags) begin
                flags <= csps_pkg::csps_flags_s'(avs_writedata[5:0]);
            end
            if (wr_ptrs) begin
                first_reg_pointer  <= avs_writedata[7:0];
                second_reg_pointer <= avs_writedata[15:8];
            end
        end
    end

    // sticky bad opcode flag, a new event wins over the clear
    always_ff @(posedge core_clk) begin
        if (!reset_n) begin
            illegal <= 1'b0;
        end else if (bad) begin
            illegal <= 1'b1;
        end else if (wr_status && avs_writedata[`CSPS_ST_ILLEGAL]) begin
            illegal <= 1'b0;
        end
    end

    // checks on the datapath and the stop sequence
    a_subb_result: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_SUBB_IM |=>
            dst_op == 8'($past(dst_op) - $past(src_op) - 8'($past(flags.c))))
        else $error("subtract with borrow result wrong");
    a_setc_carry: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_SETC |=>
            flags.c && flags[4:0] == $past(flags[4:0]) && dst_op == $past(dst_op))
        else $error("set carry changed more than c");
    a_setc_length: assert property (@(posedge core_clk) disable iff (!reset_n)
        go && new_opc == `CSPS_OPC_SETC |=> exec_busy [*4] ##1 !exec_busy)
        else $error("set carry not four cycles");
    a_asr_shift: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && is_asr |=> dst_op[7:6] == {2{$past(dst_op[7])}}
            && dst_op[5:0] == $past(dst_op[6:1]) && flags.c == $past(dst_op[0]))
        else $error("shift right result wrong");
    a_asr_flags: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && is_asr |=> flags.z == (dst_op == 8'h00) && flags.s == dst_op[7])
        else $error("shift right z or s wrong");
    a_asr_keep_dh: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && is_asr |=> !flags.v && flags.d == $past(flags.d)
            && flags.h == $past(flags.h))
        else $error("shift right v d or h wrong");
    // pointer loads
    a_ptr_both: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && ptr_sel == `CSPS_SEL_BOTH |=>
            first_reg_pointer[7:3] == {$past(src_op[7:4]), 1'b0}
            && second_reg_pointer[7:3] == {$past(src_op[7:4]), 1'b1})
        else $error("both pointer load wrong");
    a_ptr_first: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && ptr_sel == `CSPS_SEL_FIRST |=>
            first_reg_pointer[7:3] == $past(src_op[7:3])
            && $stable(second_reg_pointer) && $stable(flags))
        else $error("first pointer load wrong");
    a_ptr_second: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && ptr_sel == `CSPS_SEL_SECOND |=>
            second_reg_pointer[7:3] == $past(src_op[7:3])
            && $stable(first_reg_pointer) && $stable(flags))
        else $error("second pointer load wrong");
    a_ptr_keep_low: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR |=>
            first_reg_pointer[2:0] == $past(first_reg_pointer[2:0])
            && second_reg_pointer[2:0] == $past(second_reg_pointer[2:0]))
        else $error("pointer low bits changed");
    a_ptr_first_exact: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && src_op == 8'h52
            && first_reg_pointer[2:0] == 3'h0 |=> first_reg_pointer == 8'h50)
        else $error("first pointer not at 50h");
    a_ptr_second_exact: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && src_op == 8'h69
            && second_reg_pointer[2:0] == 3'h0 |=> second_reg_pointer == 8'h68)
        else $error("second pointer not at 68h");
    a_ptr_sel_none: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_LDPTR && ptr_sel == 2'h3 |=>
            $stable(first_reg_pointer) && $stable(second_reg_pointer))
        else $error("select 11 moved a pointer");
    // stop entry and wake
    a_stop_entry: assert property (@(posedge core_clk) disable iff (!reset_n)
        finish && opcode == `CSPS_OPC_STOP |=> stopped && !cpu_clk_en && !sys_clk_en)
        else $error("stop opcode did not halt");
    a_wake_by_irq: assert property (@(posedge core_clk) disable iff (!reset_n)
        stopped && ext_irq |=> !stopped && cpu_clk_en && sys_clk_en)
        else $error("interrupt did not wake");
    a_stop_clocks: assert property (@(posedge core_clk) disable iff (!reset_n)
        stopped |-> !cpu_clk_en && !sys_clk_en)
        else $error("clocks run while stopped");
    a_stop_retain: assert property (@(posedge core_clk) disable iff (!reset_n)
        stopped && $past(stopped) |-> $stable({dst_op, src_op, flags,
            first_reg_pointer, second_reg_pointer}))
        else $error("state lost while stopped");
    a_stop_wake: assert property (@(posedge core_clk) disable iff (!reset_n)
        stopped |=> stopped || $past(ext_irq))
        else $error("stop left without wake");
endmodule : csps_exec

/* File: bench/tb_top.sv */
`timescale 1ns/100ps
`include "csps_exec_regs.svh"
// compare two values, count the check, report a mismatch at once
`define CHECK(got, exp) begin checks_done++; if ((got) !== (exp)) begin num_errors++; \
    $display("unexpected at %0t: got %h want %h", $time, got, exp); end end
module tb_top;
    logic        core_clk      = 1'h0;       // 50 mhz core clock
    logic        reset_n       = 1'h0;       // synchronous reset, active low
    logic [2:0]  avs_address   = 3'h0;       // register word index
    logic        avs_read      = 1'h0;       // read request
    logic        avs_write     = 1'h0;       // write request
    logic [31:0] avs_writedata = 32'h0;      // write data
    logic [31:0] avs_readdata;               // read data from the slave
    logic        avs_waitrequest;            // slave stall
    logic        ext_irq       = 1'h0;       // external interrupt, wakes from stop
    logic        cpu_clk_en;                 // processor clock enable
    logic        sys_clk_en;                 // system clock enable
    int          num_errors    = 0;          // mismatches seen
    int          checks_done   = 0;          // comparisons made
    logic [31:0] seed          = 32'h901e;   // lfsr state
    logic [31:0] rd;                         // data of the last read
    logic [7:0]  r_dst;                      // destination read back
    logic [5:0]  r_fl;                       // flags read back
    logic [15:0] r_pt;                       // pointer pair read back
    logic [29:0] r_all;                      // all three read back together
    logic [7:0]  wd_hi         = 8'h00;      // write data bits 15:8
    logic [7:0]  d;                          // destination stimulus
    logic [7:0]  s;                          // source stimulus
    logic [5:0]  f;                          // flag stimulus
    logic [7:0]  p0            = 8'h00;      // expected first pointer
    logic [7:0]  p1            = 8'h00;      // expected second pointer
    logic [7:0]  src_tab [4]   = '{8'h52, 8'h69, 8'h40, 8'h8f};  // pointer corner cases

    csps_exec u_dut (
        .core_clk        (core_clk),
        .reset_n         (reset_n),
        .avs_address     (avs_address),
        .avs_read        (avs_read),
        .avs_write       (avs_write),
        .avs_writedata   (avs_writedata),
        .avs_readdata    (avs_readdata),
        .avs_waitrequest (avs_waitrequest),
        .ext_irq         (ext_irq),
        .cpu_clk_en      (cpu_clk_en),
        .sys_clk_en      (sys_clk_en)
    );

    // free running clock, 20 ns period
    always #10 core_clk = ~core_clk;

    // one step of the pseudo random sequence
    function automatic logic [31:0] lfsr_step(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction : lfsr_step

    // expected result and flags of the arithmetic shift right
    function automatic logic [13:0] exp_asr(input logic [7:0] x, input logic [5:0] fl);
        logic [7:0] r;
        r = {x[7], x[7:1]};
        return {r, x[0], r == 8'h00, r[7], 1'h0, fl[1:0]};
    endfunction : exp_asr

    // expected result and flags of subtract with borrow
    function automatic logic [13:0] exp_subb(input logic [7:0] x, input logic [7:0] y,
                                             input logic c);
        logic [8:0] r;
        r = {1'h0, x} - {1'h0, y} - {8'h00, c};
        return {r[7:0], r[8], r[7:0] == 8'h00, r[7], (x[7] != y[7]) && (r[7] == y[7]),
                1'h1, {1'h0, x[3:0]} < ({1'h0, y[3:0]} + {4'h0, c})};
    endfunction : exp_subb

    // print counts and verdict, then end the run
    task automatic report_and_stop;
        $display("errors %0d checks %0d", num_errors, checks_done);
        if (num_errors == 0 && checks_done > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop

    // one avalon transfer, held until waitrequest is seen low at a rising edge
    task automatic bus_op(input logic wr, input logic [2:0] a, input logic [7:0] wd);
        logic ws;
        int   n;
        ws = 1'h1;
        n = 0;
        avs_address <= a;
        avs_writedata <= {16'h0000, wd_hi, wd};
        avs_read <= ~wr;
        avs_write <= wr;
        // waitrequest and read data are taken as they stand at the rising edge
        while (ws) begin
            @(posedge core_clk);
            ws = avs_waitrequest;
            rd = avs_readdata;
            n++;
            if (n > 20) begin
                num_errors++;
                $display("unexpected at %0t: bus never answered", $time);
                report_and_stop();
            end
        end
        avs_read <= 1'h0;
        avs_write <= 1'h0;
        @(posedge core_clk);
    endtask : bus_op

    // poll status until the busy bit drops, bounded
    task automatic wait_idle;
        for (int n = 0; n < 30; n++) begin
            bus_op(1'h0, `CSPS_OFS_STATUS, 8'h00);
            if (rd[`CSPS_ST_BUSY] === 1'h0) begin
                return;
            end
        end
        num_errors++;
        $display("unexpected at %0t: busy never fell", $time);
        report_and_stop();
    endtask : wait_idle

    // load operands, issue an opcode, wait, read back the results
    task automatic exec(input logic [7:0] op, input logic [7:0] dv, input logic [7:0] sv,
                        input logic [5:0] fv);
        bus_op(1'h1, `CSPS_OFS_DST, dv);
        bus_op(1'h1, `CSPS_OFS_SRC, sv);
        bus_op(1'h1, `CSPS_OFS_FLAGS, {2'h0, fv});
        bus_op(1'h1, `CSPS_OFS_CMD, op);
        wait_idle();
        bus_op(1'h0, `CSPS_OFS_DST, 8'h00);
        r_dst = rd[7:0];
        bus_op(1'h0, `CSPS_OFS_FLAGS, 8'h00);
        r_fl = rd[5:0];
        bus_op(1'h0, `CSPS_OFS_PTRS, 8'h00);
        r_pt = rd[15:0];
        r_all = {r_dst, r_fl, r_pt};
    endtask : exec

    // main sequence
    initial begin
        repeat (4) @(posedge core_clk);
        reset_n <= 1'h1;
        @(posedge core_clk);
        // shift right, both encodings, first case is 9ah with carry set
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_step(seed);
            d = (i == 0) ? 8'h9a : seed[7:0];
            f = (i == 0) ? 6'h20 : seed[13:8];
            exec(i[0] ? `CSPS_OPC_ASR_IR : `CSPS_OPC_ASR_R, d, 8'h00, f);
            `CHECK(r_all, {exp_asr(d, f), p1, p0})
        end
        // subtract with borrow, first case 20h minus 8ah with carry
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_step(seed);
            d = (i == 0) ? 8'h20 : seed[7:0];
            s = (i == 0) ? 8'h8a : seed[15:8];
            f = (i == 0) ? 6'h20 : seed[21:16];
            exec(`CSPS_OPC_SUBB_IM, d, s, f);
            `CHECK(r_all, {exp_subb(d, s, f[5]), p1, p0})
        end
        // set carry leaves everything but c alone
        for (int i = 0; i < 6; i++) begin
            seed = lfsr_step(seed);
            f = seed[5:0];
            exec(`CSPS_OPC_SETC, seed[15:8], 8'h00, f);
            `CHECK(r_all, {seed[15:8], f | 6'h20, p1, p0})
        end
        // pointer loads: corner table first, then random sources
        for (int i = 0; i < 12; i++) begin
            seed = lfsr_step(seed);
            s = (i < 4) ? src_tab[i] : seed[7:0];
            f = seed[13:8];
            if (i >= 4) begin
                // preset the pair at random so that kept low bits are seen
                p0 = seed[31:24];
                p1 = seed[23:16];
                wd_hi = p1;
                bus_op(1'h1, `CSPS_OFS_PTRS, p0);
                wd_hi = 8'h00;
            end
            if (s[1:0] == 2'h0) begin
                p0 = {s[7:4], 1'h0, p0[2:0]};
                p1 = {s[7:4], 1'h1, p1[2:0]};
            end else if (s[1:0] == 2'h2) begin
                p0 = {s[7:3], p0[2:0]};
            end else if (s[1:0] == 2'h1) begin
                p1 = {s[7:3], p1[2:0]};
            end
            exec(`CSPS_OPC_LDPTR, 8'h3c, s, f);
            `CHECK(r_all, {8'h3c, f, p1, p0})
            if (i < 2) begin
                `CHECK(i == 0 ? r_pt[7:0] : r_pt[15:8], i == 0 ? 8'h50 : 8'h68)
            end
        end
        // unknown opcode: nothing runs, sticky flag until a one is written
        bus_op(1'h1, `CSPS_OFS_CMD, 8'h22);
        bus_op(1'h0, `CSPS_OFS_STATUS, 8'h00);
        `CHECK(rd[2:0], 3'h4)
        bus_op(1'h1, `CSPS_OFS_STATUS, 8'h04);
        bus_op(1'h0, `CSPS_OFS_STATUS, 8'h00);
        `CHECK(rd[2:0], 3'h0)
        // stop: clocks halt, contents kept, writes ignored
        exec(`CSPS_OPC_STOP, 8'h5a, 8'h00, 6'h15);
        `CHECK({cpu_clk_en, sys_clk_en}, 2'h0)
        `CHECK(r_all, {8'h5a, 6'h15, p1, p0})
        bus_op(1'h1, `CSPS_OFS_DST, 8'ha5);
        bus_op(1'h0, `CSPS_OFS_DST, 8'h00);
        `CHECK(rd[7:0], 8'h5a)
        bus_op(1'h0, `CSPS_OFS_STATUS, 8'h00);
        `CHECK(rd[2:0], 3'h2)
        repeat (10) @(posedge core_clk);
        `CHECK({cpu_clk_en, sys_clk_en}, 2'h0)
        // wake by external interrupt
        ext_irq <= 1'h1;
        @(posedge core_clk);
        ext_irq <= 1'h0;
        repeat (3) @(posedge core_clk);
        `CHECK({cpu_clk_en, sys_clk_en}, 2'h3)
        // stop again and wake by a reset held several cycles
        exec(`CSPS_OPC_STOP, 8'h11, 8'h00, 6'h00);
        `CHECK({cpu_clk_en, sys_clk_en}, 2'h0)
        reset_n <= 1'h0;
        repeat (4) @(posedge core_clk);
        reset_n <= 1'h1;
        @(posedge core_clk);
        @(posedge core_clk);
        `CHECK({cpu_clk_en, sys_clk_en}, 2'h3)
        report_and_stop();
    end
endmodule : tb_top
